// File: include/tws_pkg.sv
/*
 two-wire slave control block: constants and carrier types.
 assumes: serial pins are sampled by a 40 MHz core clock.
*/
// Contract
// - idle bus leaves data and clock lines high; slave releases data.
// - data falling while clock high is a start; transfer begins.
// - data rising while clock high is a stop; transfer ends.
// - repeated start restarts the transfer from the address byte.
// - one data byte per transfer; further bytes are not acknowledged.
// - receiver holds data low through the ninth clock high phase.
// - unmatched address leaves data high in the acknowledge slot.
// - slave that cannot take more bytes does not acknowledge them.
// - output differential by default; register 13 bit 6 selects single-ended.
// - register 13 bit 7 moves single-ended drive to negative output.
// - register 0 resets to 41h: chip enable 1, reserved field 4h.
// - register 0 bit 7 resets all interface state; self-clears, reads zero. Code resets state, bit count, ack and tx flags; sh_q, rw_q, ra_q keep values.
// - register 0 bit 1 restores all registers; self-clears, reads zero.
// - register 1 bit 7 enables the monitor pin fault trigger.
// - register 1 bits 6:5 choose photodiode monitor range.
// - register 1 bit 4 selects open-loop bias control.
// - register 1 bit 3 switches fault detection on.
// - register 1 bit 2 enables bias; clearing it clears latched fault.
// - register 1 bit 1 bias sink, bit 0 photodiode cathode to supply.
// - register 2 bit 1 optical loopback, bit 0 electrical loopback.
// - register 3 bits 7, 6, 4 enable, oscillator, reset; reset zero.
// - register 3 bits 2:0 choose converter input; 1xx reserved.
// - transfer: start, address 0001000 plus direction, register, data, stop.
`default_nettype none
package tws_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h08;
  localparam logic [7:0] REG_CORE0     = 8'h00;
  localparam logic [7:0] REG_BIAS      = 8'h01;
  localparam logic [7:0] REG_LOOP      = 8'h02;
  localparam logic [7:0] REG_CONV      = 8'h03;
  localparam logic [7:0] REG_TXOUT     = 8'h0D;
  localparam logic [7:0] RST_CORE0     = 8'h41;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam int         BIT_GLOBAL    = 7;
  localparam int         BIT_SOFT      = 1;
  localparam int         BIT_CHIP_EN   = 0;
  localparam logic [7:0] CORE0_SC_MASK = 8'h82;
  localparam int         BIT_SE_SEL    = 6;
  localparam int         BIT_SIDE_SEL  = 7;
  localparam int         NUM_REGS      = 16;

  typedef struct packed {
    logic       chip_enable;
    logic       pd_monitor_fault_trigger_en;
    logic [1:0] pd_range;
    logic       open_loop_enable;
    logic       fault_detect_enable;
    logic       laser_bias_enable;
    logic       bias_pin_polarity;
    logic       photodiode_polarity;
    logic       optical_loopback_sel;
    logic       electrical_loopback_sel;
    logic       converter_enable;
    logic       converter_osc_enable;
    logic       converter_reset;
    logic [2:0] converter_input_select;
    logic       single_ended_select;
    logic       output_side_select;
  } tws_ctrl_t;

  typedef struct packed {
    logic drive_pos;
    logic drive_neg;
  } tws_txout_t;
endpackage
`default_nettype wire

// File: hw/tws_regmem.sv
/*
 small register memory: one write port, registered read data.
 assumes: clear pulse restores all entries to their reset values.
*/
`default_nettype none
module tws_regmem #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_ni,
  input  wire logic       clear_i,
  // access
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic [DEPTH*8-1:0] flat_o
);
  logic [7:0] mem_q [DEPTH];
  wire        hit = addr_i < 8'(DEPTH);

  initial if (DEPTH < 14 || DEPTH > 256) $error("bad depth");

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    localparam logic [7:0] RV =
      (i == 0) ? tws_pkg::RST_CORE0 : tws_pkg::RST_ZERO;
    always_ff @(posedge clk_i or negedge rst_ni) begin
      if (!rst_ni) mem_q[i] <= RV;
      else if (clear_i) mem_q[i] <= RV;
      else if (we_i && addr_i == 8'(i)) begin
        // self-clearing bits are never stored
        mem_q[i] <= (i == 0) ? (wdata_i & ~tws_pkg::CORE0_SC_MASK)
                             : wdata_i;
      end
    end
    assign flat_o[i*8 +: 8] = mem_q[i];
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) rdata_o <= 8'h00;
    else rdata_o <= hit ? mem_q[addr_i[$clog2(DEPTH)-1:0]] : 8'h00;
  end
endmodule
`default_nettype wire

// File: hw/tws_core.sv
/*
 two-wire serial slave with core control registers.
 assumes: the master drives the serial clock; pins are oversampled.
*/
`default_nettype none
module tws_core (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  // serial pins
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe_o,
  // control outputs
  output tws_pkg::tws_ctrl_t  ctrl_o,
  output tws_pkg::tws_txout_t txout_o,
  output logic               fault_o,
  // fault source
  input  wire logic          fault_event_i
);
  ////////////////////////////////////////////////////////////////////////
  logic rst_s1_q, rst_n;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) {rst_n, rst_s1_q} <= 2'b00;
    else {rst_n, rst_s1_q} <= {rst_s1_q, 1'b1};
  end

  // pin synchronisers, then one history stage for edges
  logic [1:0] scl_sy_q, sda_sy_q;
  logic       scl_q, sda_q, scl_p_q, sda_p_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
      {scl_p_q, sda_p_q} <= 2'b11;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      {scl_p_q, sda_p_q} <= {scl_q, sda_q};
    end
  end
  assign scl_q = scl_sy_q[1];
  assign sda_q = sda_sy_q[1];

  wire scl_rise = scl_q & ~scl_p_q;
  wire scl_fall = ~scl_q & scl_p_q;
  wire start_c  = scl_q & scl_p_q & sda_p_q & ~sda_q;
  wire stop_c   = scl_q & scl_p_q & ~sda_p_q & sda_q;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_REG, S_WDATA, S_RDATA, S_DONE
  } tws_state_t;

  tws_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic       rw_q, rw_d;
  logic [7:0] ra_q, ra_d;
  logic       ack_q, ack_d;    // pulling low in ninth slot
  logic       tx_q, tx_d;      // driving read data
  logic       we_d, drv_d;
  logic       sc_global, sc_soft, global_q;
  logic [7:0] rdata;
  logic [tws_pkg::NUM_REGS*8-1:0] flat;

  wire        byte_done = scl_rise && bit_q == 4'd7;
  wire [7:0]  byte_in   = {sh_q[6:0], sda_q};
  wire        addr_hit  = byte_in[7:1] == tws_pkg::DEV_ADDR;
  // bit_q counts clock rises of one slot group: 8 bits, then the ack
  wire        ack_slot  = scl_fall && bit_q == 4'd8;
  wire        slot_end  = scl_fall && bit_q == 4'd9;
  wire        tx_load   = slot_end && ack_q && state_q == S_RDATA && !tx_q;

  // read byte uses the shift register while transmitting
  logic tx_bit;
  assign tx_bit = sh_q[7 - bit_q[2:0]];

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    rw_d    = rw_q;
    ra_d    = ra_q;
    ack_d   = ack_q;
    tx_d    = tx_q;
    we_d    = 1'b0;
    drv_d   = sda_oe_o;
    if (start_c) begin
      state_d = S_ADDR;
      bit_d   = 4'd0;
      ack_d   = 1'b0;
      tx_d    = 1'b0;
      drv_d   = 1'b0;
    end else if (stop_c) begin
      state_d = S_IDLE;
      ack_d   = 1'b0;
      tx_d    = 1'b0;
      drv_d   = 1'b0;
    end else if (state_q != S_IDLE) begin
      if (scl_rise && bit_q < 4'd9) begin
        bit_d = bit_q + 4'd1;
      end
      if (scl_rise && bit_q < 4'd8 && !tx_q) begin
        sh_d  = byte_in;
      end
      if (byte_done && !tx_q) begin
        case (state_q)
          S_ADDR: begin
            rw_d = byte_in[0];
            if (addr_hit) begin
              state_d = byte_in[0] ? S_RDATA : S_REG;
              ack_d   = 1'b1;
            end else begin
              state_d = S_DONE;
            end
          end
          S_REG: begin
            ra_d    = byte_in;
            ack_d   = 1'b1;
            state_d = rw_q ? S_DONE : S_WDATA;
          end
          S_WDATA: begin
            ack_d   = 1'b1;
            we_d    = 1'b1;
            state_d = S_DONE;
          end
          S_DONE: ack_d = 1'b0;
          default: ;
        endcase
      end
      // data line only changes after a clock fall, never while high
      if (ack_slot) begin
        drv_d = ack_q;
      end else if (slot_end) begin
        bit_d = 4'd0;
        ack_d = 1'b0;
        drv_d = 1'b0;
        if (tx_load) begin
          tx_d  = 1'b1;
          sh_d  = rdata;
          drv_d = !rdata[7];
        end else if (tx_q) begin
          tx_d    = 1'b0;
          state_d = S_DONE;
        end
      end else if (scl_fall && tx_q && bit_q != 4'd0) begin
        drv_d = !tx_bit;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bit_q   <= 4'd0;
      sh_q    <= 8'h00;
      rw_q    <= 1'b0;
      ra_q    <= 8'h00;
      ack_q   <= 1'b0;
      tx_q    <= 1'b0;
    end else if (global_q) begin
      state_q <= S_IDLE;
      bit_q   <= 4'd0;
      ack_q   <= 1'b0;
      tx_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      rw_q    <= rw_d;
      ra_q    <= ra_d;
      ack_q   <= ack_d;
      tx_q    <= tx_d;
      // while sending, hold the byte; shifting-in is for writes
      sh_q    <= sh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-clearing strobes are decoded from the write itself
  assign sc_global = we_d && ra_q == tws_pkg::REG_CORE0
                     && byte_in[tws_pkg::BIT_GLOBAL];
  assign sc_soft   = we_d && ra_q == tws_pkg::REG_CORE0
                     && byte_in[tws_pkg::BIT_SOFT];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) global_q <= 1'b0;
    else global_q <= sc_global;
  end

  tws_regmem #(
    .DEPTH (tws_pkg::NUM_REGS)
  ) u_mem (
    .clk_i   (core_clk_i),
    .rst_ni  (rst_n),
    .clear_i (sc_soft | sc_global),
    .we_i    (we_d && !sc_soft && !sc_global),
    .addr_i  (ra_d),
    .wdata_i (byte_in),
    .rdata_o (rdata),
    .flat_o  (flat)
  );

  wire [7:0] r0 = flat[8*tws_pkg::REG_CORE0  +: 8];
  wire [7:0] r1 = flat[8*tws_pkg::REG_BIAS   +: 8];
  wire [7:0] r2 = flat[8*tws_pkg::REG_LOOP   +: 8];
  wire [7:0] r3 = flat[8*tws_pkg::REG_CONV   +: 8];
  wire [7:0] rd = flat[8*tws_pkg::REG_TXOUT  +: 8];

  tws_pkg::tws_ctrl_t  ctrl_d;
  tws_pkg::tws_txout_t txo_d;
  always_comb begin
    ctrl_d.chip_enable                 = r0[tws_pkg::BIT_CHIP_EN];
    ctrl_d.pd_monitor_fault_trigger_en = r1[7];
    ctrl_d.pd_range                    = r1[6:5];
    ctrl_d.open_loop_enable            = r1[4];
    ctrl_d.fault_detect_enable         = r1[3];
    ctrl_d.laser_bias_enable           = r1[2];
    ctrl_d.bias_pin_polarity           = r1[1];
    ctrl_d.photodiode_polarity         = r1[0];
    ctrl_d.optical_loopback_sel        = r2[1];
    ctrl_d.electrical_loopback_sel     = r2[0];
    ctrl_d.converter_enable            = r3[7];
    ctrl_d.converter_osc_enable        = r3[6];
    ctrl_d.converter_reset             = r3[4];
    ctrl_d.converter_input_select      = r3[2:0];
    ctrl_d.single_ended_select         = rd[tws_pkg::BIT_SE_SEL];
    ctrl_d.output_side_select          = rd[tws_pkg::BIT_SIDE_SEL];
    // differential drives both sides
    txo_d.drive_pos = !ctrl_d.single_ended_select
                      || !ctrl_d.output_side_select;
    txo_d.drive_neg = !ctrl_d.single_ended_select
                      || ctrl_d.output_side_select;
  end

  ////////////////////////////////////////////////////////////////////////
  logic fault_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_o   <= '0;
      txout_o  <= 2'b11;
      fault_o  <= 1'b0;
      fault_q  <= 1'b0;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      ctrl_o  <= ctrl_d;
      txout_o <= txo_d;
      // bias bit cleared wins: the fault cannot be re-latched meanwhile
      if (!ctrl_d.laser_bias_enable) fault_q <= 1'b0;
      else if (fault_event_i && ctrl_d.fault_detect_enable)
        fault_q <= 1'b1;
      fault_o  <= fault_q;
      sda_o    <= 1'b0;
      // open drain: release means high, idle never drives
      sda_oe_o <= global_q ? 1'b0 : drv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_addr_ok;
    state_q == S_ADDR && byte_done && addr_hit;
  endsequence

  a_ack_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    s_addr_ok and (!start_c && !stop_c) |=> ack_q)
    else $error("address match not acknowledged");
  a_nack_miss: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    state_q == S_ADDR && byte_done && !addr_hit && !start_c && !stop_c
    |=> !ack_q ##1 !sda_oe_o)
    else $error("foreign address acknowledged");
  a_stop_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    stop_c && !global_q |=> state_q == S_IDLE)
    else $error("stop did not end transfer");
  a_start_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    start_c && !global_q |=> state_q == S_ADDR && bit_q == 4'd0)
    else $error("start not detected");
  a_no_second: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    state_q == S_DONE && byte_done && !start_c && !stop_c |=> !ack_q)
    else $error("second byte acknowledged");
  a_idle_free: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    state_q == S_IDLE && $past(state_q) == S_IDLE |-> ##1 !sda_oe_o)
    else $error("driving data line while idle");
  a_se_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    ctrl_o.single_ended_select && ctrl_o.output_side_select
    && $stable(ctrl_o) |-> !txout_o.drive_pos && txout_o.drive_neg)
    else $error("wrong single-ended side");
  a_fault_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !ctrl_d.laser_bias_enable |=> ##1 !fault_o)
    else $error("fault not cleared by bias bit");
endmodule
`default_nettype wire

// File: tb/tws_master_model.sv
/*
 two-wire bus master model: frames, bytes, acknowledge slots.
 assumes: the bench resolves the open-drain data line with a pull-up.
*/
`default_nettype none
module tws_master_model (
  // clock
  input  wire logic clk_i,
  // serial bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one step is 50 ns, a serial period is four steps
  task automatic stp(input int n);
    repeat (2 * n) @(posedge clk_i);
  endtask
  // also used as repeated start inside a frame
  task automatic start();
    stp(1);
    sda_o <= 1'b1;
    stp(1);
    scl_o <= 1'b1;
    stp(2);
    sda_o <= 1'b0;
    stp(2);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    stp(1);
    sda_o <= 1'b0;
    stp(1);
    scl_o <= 1'b1;
    stp(2);
    sda_o <= 1'b1;
    stp(2);
  endtask
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    stp(1);
    sda_o <= b;
    stp(1);
    scl_o <= 1'b1;
    stp(1);
    s = sda_i;
    stp(1);
    scl_o <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [7:0] r, d, output logic [2:0] ak);
    logic [7:0] x;
    start();
    xfer({tws_pkg::DEV_ADDR, 1'b0}, x, ak[2]);
    xfer(r, x, ak[1]);
    xfer(d, x, ak[0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d,
                    output logic [2:0] ak);
    logic [7:0] x;
    logic       n;
    start();
    xfer({tws_pkg::DEV_ADDR, 1'b0}, x, ak[2]);
    xfer(r, x, ak[1]);
    start();
    xfer({tws_pkg::DEV_ADDR, 1'b1}, x, ak[0]);
    xfer(8'hFF, d, n);
    stop();
  endtask
endmodule
`default_nettype wire

// File: tb/tws_core_tb.sv
/*
 bench for the two-wire control block: register traffic and fields.
 assumes: master model drives the bus, bench resolves open drain.
*/
`default_nettype none
module tws_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                core_clk_i;
  logic                rstn_i;
  logic                fault_event_i;
  logic                scl;
  logic                sda_m;
  logic                sda_o;
  logic                sda_oe_o;
  logic                fault_o;
  tws_pkg::tws_ctrl_t  ctrl_o;
  tws_pkg::tws_txout_t txout_o;
  logic [2:0]          ak;
  logic [7:0]          rdat;
  logic                n;
  int                  err_total;
  int                  compares;
  wire logic           sda_w;
  wire logic [7:0]     bias_f;
  wire logic [7:0]     conv_f;
  assign sda_w  = sda_m & (~sda_oe_o | sda_o);
  assign bias_f = {ctrl_o.pd_monitor_fault_trigger_en, ctrl_o.pd_range,
                   ctrl_o.open_loop_enable, ctrl_o.fault_detect_enable,
                   ctrl_o.laser_bias_enable, ctrl_o.bias_pin_polarity,
                   ctrl_o.photodiode_polarity};
  assign conv_f = {ctrl_o.converter_enable, ctrl_o.converter_osc_enable,
                   1'b0, ctrl_o.converter_reset, 1'b0,
                   ctrl_o.converter_input_select};
  ////////////////////////////////////////////////////////////
  tws_core dut_u (
    .core_clk_i    (core_clk_i),
    .rstn_i        (rstn_i),
    .scl_i         (scl),
    .sda_i         (sda_w),
    .sda_o         (sda_o),
    .sda_oe_o      (sda_oe_o),
    .ctrl_o        (ctrl_o),
    .txout_o       (txout_o),
    .fault_o       (fault_o),
    .fault_event_i (fault_event_i)
  );
  tws_master_model m_u (
    .clk_i (core_clk_i),
    .sda_i (sda_w),
    .scl_o (scl),
    .sda_o (sda_m)
  );
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic check(input string nm, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] r, d);
    m_u.wr(r, d, ak);
    check("write acks", {5'h00, ak}, 8'h07);
  endtask
  task automatic rchk(input string nm, input logic [7:0] r, e);
    m_u.rd(r, rdat, ak);
    check("read acks", {5'h00, ak}, 8'h07);
    check(nm, rdat, e);
  endtask
  task automatic pulse();
    @(posedge core_clk_i);
    fault_event_i <= 1'b1;
    @(posedge core_clk_i);
    fault_event_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  // a serial transfer is about 300 core cycles
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    results();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] bias_v [2];
    logic [7:0] se_v [3];
    logic [1:0] se_e [3];
    bias_v = '{8'hA5, 8'h5A};
    se_v = '{8'h40, 8'hC0, 8'h00};
    se_e = '{2'b10, 2'b01, 2'b11};
    rstn_i = 1'b0;
    fault_event_i = 1'b0;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check("chip enable", {7'h00, ctrl_o.chip_enable}, 8'h01);
    check("txout reset", {6'h00, txout_o}, 8'h03);
    check("bias reset", bias_f, 8'h00);
    rchk("reg0 reset", tws_pkg::REG_CORE0, tws_pkg::RST_CORE0);
    rchk("reg3 reset", tws_pkg::REG_CONV, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wreg(tws_pkg::REG_BIAS, bias_v[i]);
      check("bias fields", bias_f, bias_v[i]);
      rchk("reg1", tws_pkg::REG_BIAS, bias_v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(tws_pkg::REG_CONV, 8'hD0 | 8'(i));
      check("conv fields", conv_f, 8'hD0 | 8'(i));
    end
    for (int i = 1; i < 4; i++) begin
      wreg(tws_pkg::REG_LOOP, 8'(i));
      check("loopback", {6'h00, ctrl_o.optical_loopback_sel,
            ctrl_o.electrical_loopback_sel}, 8'(i));
    end
    for (int i = 0; i < 3; i++) begin
      wreg(tws_pkg::REG_TXOUT, se_v[i]);
      check("txout", {6'h00, txout_o}, {6'h00, se_e[i]});
    end
    m_u.start();
    m_u.xfer(8'h12, rdat, ak[2]);
    m_u.xfer(tws_pkg::REG_LOOP, rdat, ak[1]);
    m_u.xfer(8'h00, rdat, ak[0]);
    m_u.stop();
    check("foreign acks", {5'h00, ak}, 8'h00);
    check("foreign write", {7'h00, ctrl_o.optical_loopback_sel}, 8'h01);
    m_u.start();
    m_u.xfer({tws_pkg::DEV_ADDR, 1'b0}, rdat, ak[2]);
    m_u.xfer(tws_pkg::REG_LOOP, rdat, ak[1]);
    m_u.xfer(8'h01, rdat, ak[0]);
    m_u.xfer(8'h02, rdat, n);
    m_u.stop();
    check("first byte acks", {5'h00, ak}, 8'h07);
    check("second byte ack", {7'h00, n}, 8'h00);
    rchk("one byte kept", tws_pkg::REG_LOOP, 8'h01);
    check("idle release", {7'h00, sda_oe_o}, 8'h00);
    wreg(tws_pkg::REG_BIAS, 8'h04);
    pulse();
    check("fault off", {7'h00, fault_o}, 8'h00);
    wreg(tws_pkg::REG_BIAS, 8'h0C);
    pulse();
    check("fault latch", {7'h00, fault_o}, 8'h01);
    wreg(tws_pkg::REG_BIAS, 8'h08);
    check("fault clear", {7'h00, fault_o}, 8'h00);
    wreg(tws_pkg::REG_CORE0, 8'h40);
    check("chip off", {7'h00, ctrl_o.chip_enable}, 8'h00);
    wreg(tws_pkg::REG_BIAS, 8'hFF);
    wreg(tws_pkg::REG_CORE0, 8'h42);
    check("soft bias", bias_f, 8'h00);
    rchk("soft reg0", tws_pkg::REG_CORE0, 8'h41);
    wreg(tws_pkg::REG_BIAS, 8'h12);
    wreg(tws_pkg::REG_TXOUT, 8'h40);
    m_u.wr(tws_pkg::REG_CORE0, 8'hC1, ak);
    check("global bias", bias_f, 8'h00);
    check("global txout", {6'h00, txout_o}, 8'h03);
    rchk("global reg0", tws_pkg::REG_CORE0, 8'h41);
    results();
  end
endmodule
`default_nettype wire
